// ===== icu_pkg.sv
// Constants, register map and shared types of the interrupt context unit
//
// Function
// RULE1 - On entry save pc, status, pointer, accumulator; ignore further requests.
// RULE2 - On entry the program counter is forced to vector address zero.
// RULE3 - On entry the three page select bits of status are cleared.
// RULE4 - Return restores the saved context and re-enables interrupt acceptance.
// RULE5 - Enabled rollover interrupt fires when the counter wraps from FF to 00.
// RULE6 - Rollover to service routine takes 3 cycles single-cycle mode, else 8.
// RULE7 - After return, 3 cycles single-cycle mode, else 8, before main code resumes.
// RULE8 - Any instruction altering the program counter flushes and refills the pipeline.
// RULE9 - Eight port B pins each request an interrupt on a change of state.
// RULE10 - Each port B source has its own enable mask and edge direction bit.
// RULE11 - Port B edge to service routine takes 5 cycles single-cycle mode, else 10; the code takes 8, else 13, counted from the pin change.
// RULE12 - Larger variants also take timer overflow, compare and capture requests.
// RULE13 - Rollover interrupt enabled when the disable bit is zero, suppressed when one.
package icu_pkg;

    localparam int PC_W = 11;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int PINS = 8;
    localparam int TMR_EV = 3;
    localparam int SRC_W = PINS + 1 + TMR_EV;

    // Register word offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_EDGE_EN = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_EDGE_DIR = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_RTC = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_SAVED_PC = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_STATE = 4'h7;

    // Control field positions
    localparam int CTRL_ROLL_DIS = 0;
    localparam int CTRL_SINGLE = 1;

    // Status and mask field positions
    localparam int ST_EDGE_LO = 0;
    localparam int ST_ROLL = 8;
    localparam int ST_TMR_LO = 9;

    // Reset values
    localparam logic RST_ROLL_DIS = 1'h1;
    localparam logic RST_SINGLE = 1'h0;
    localparam logic [PINS-1:0] RST_EDGE_EN = 8'h00;
    localparam logic [PINS-1:0] RST_EDGE_DIR = 8'h00;
    localparam logic [SRC_W-1:0] RST_MASK = 12'h000;
    localparam logic [7:0] RST_RTC = 8'h00;

    localparam logic [7:0] RTC_MAX = 8'hFF;
    localparam logic [7:0] PAGE_CLR = 8'h1F;
    localparam logic [PC_W-1:0] VECTOR_ADDR = 11'h000;

    // Latencies in instruction cycles
    localparam logic [3:0] LAT_ROLL_SINGLE = 4'h3;
    localparam logic [3:0] LAT_ROLL_MULTI = 4'h8;
    localparam logic [3:0] LAT_EDGE_SINGLE = 4'h5;
    localparam logic [3:0] LAT_EDGE_MULTI = 4'hA;
    localparam logic [3:0] RET_SINGLE = 4'h3;
    localparam logic [3:0] RET_MULTI = 4'h8;

    typedef enum logic [3:0] {
        ICU_IDLE = 4'b0001,
        ICU_WAIT = 4'b0010,
        ICU_SERVICE = 4'b0100,
        ICU_RETURN = 4'b1000
    } icu_fsm_t;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [7:0] status;
        logic [7:0] file_select_pointer;
        logic [7:0] w;
    } icu_ctx_t;

endpackage

// ===== icu_edge_sync.sv
// Pin synchroniser with per-pin edge direction detection
module icu_edge_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and configuration
    input wire logic [W-1:0] pins,
    input wire logic [W-1:0] falling,
    // Detected edges, one-cycle pulses
    output logic [W-1:0] edge_seen
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
        logic [W-1:0] hit;
    } icu_sync_t;

    icu_sync_t s;
    icu_sync_t n;

    always_comb begin
        n = s;
        n.meta = pins;
        n.sync = s.meta;
        n.prev = s.sync;
        // Direction 1 selects high-to-low, 0 low-to-high
        n.hit = (s.sync & ~s.prev & ~falling) | (~s.sync & s.prev & falling); // RULE9 RULE10
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign edge_seen = s.hit;

endmodule

// ===== icu_top.sv
// Interrupt entry, return and context shadowing for the core
module icu_top #(
    parameter bit HAS_TIMERS = 1'b1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [icu_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [icu_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [icu_pkg::DATA_W-1:0] REG_RDATA,
    // Core context and instruction events
    input wire icu_pkg::icu_ctx_t CORE_CTX,
    input wire logic CORE_RETURN_FROM_INTERRUPT,
    input wire logic CORE_PC_CHANGE,
    // Event sources
    input wire logic RTC_TICK,
    input wire logic [icu_pkg::PINS-1:0] PORT_B,
    input wire logic [icu_pkg::TMR_EV-1:0] TIMER_EVT,
    // Context load toward the core
    output icu_pkg::icu_ctx_t CTX_OUT,
    output logic CTX_LOAD,
    output logic PIPE_FLUSH,
    output logic IN_SERVICE,
    output logic CORE_HOLD,
    // Interrupt line
    output logic IRQ
);

    typedef struct packed {
        icu_pkg::icu_fsm_t fsm;
        logic [3:0] cnt;
        logic roll_dis;
        logic single;
        logic [icu_pkg::PINS-1:0] edge_en;
        logic [icu_pkg::PINS-1:0] edge_dir;
        logic [icu_pkg::SRC_W-1:0] status;
        logic [icu_pkg::SRC_W-1:0] mask;
        logic [7:0] rtc;
        icu_pkg::icu_ctx_t saved;
        icu_pkg::icu_ctx_t out;
        logic load;
        logic flush;
        logic in_service;
        logic hold;
        logic irq;
        logic [icu_pkg::DATA_W-1:0] rdata;
    } icu_state_t;

    icu_state_t s;
    icu_state_t n;

    logic [icu_pkg::PINS-1:0] pin_edge;
    logic roll;
    logic [icu_pkg::TMR_EV-1:0] tmr_ev;
    logic [icu_pkg::SRC_W-1:0] events;
    logic [icu_pkg::SRC_W-1:0] clr;
    logic [icu_pkg::SRC_W-1:0] req;
    logic edge_only;
    logic [3:0] lat;
    logic [3:0] ret_lat;

    icu_edge_sync #(
        .W(icu_pkg::PINS)
    ) u_edge (
        .clk(CLK),
        .rst(RST),
        .pins(PORT_B),
        .falling(s.edge_dir),
        .edge_seen(pin_edge)
    );

    always_comb begin
        n = s;
        n.load = 1'b0;
        n.flush = 1'b0;
        n.rdata = '0;
        clr = '0;

        // Real-time counter and its wrap event
        if (RTC_TICK) begin
            n.rtc = s.rtc + 8'h01;
        end
        roll = RTC_TICK && (s.rtc == icu_pkg::RTC_MAX) && !s.roll_dis; // RULE5 RULE13
        tmr_ev = HAS_TIMERS ? TIMER_EVT : '0; // RULE12
        events = {tmr_ev, roll, pin_edge & s.edge_en}; // RULE9 RULE10

        // Register writes
        if (REG_WR) begin
            if (REG_ADDR == icu_pkg::OFS_CTRL) begin
                n.roll_dis = REG_WDATA[icu_pkg::CTRL_ROLL_DIS]; // RULE13
                n.single = REG_WDATA[icu_pkg::CTRL_SINGLE];
            end else if (REG_ADDR == icu_pkg::OFS_EDGE_EN) begin
                n.edge_en = REG_WDATA[icu_pkg::PINS-1:0]; // RULE10
            end else if (REG_ADDR == icu_pkg::OFS_EDGE_DIR) begin
                n.edge_dir = REG_WDATA[icu_pkg::PINS-1:0]; // RULE10
            end else if (REG_ADDR == icu_pkg::OFS_IRQ_STATUS) begin
                clr = REG_WDATA[icu_pkg::SRC_W-1:0];
            end else if (REG_ADDR == icu_pkg::OFS_IRQ_MASK) begin
                n.mask = REG_WDATA[icu_pkg::SRC_W-1:0];
            end else if (REG_ADDR == icu_pkg::OFS_RTC) begin
                // Software load wins over a tick in the same cycle
                n.rtc = REG_WDATA[7:0];
            end
        end

        // New events win over a write-one clear
        n.status = (s.status & ~clr) | events;

        // Pending requests, timer sources share the rollover latency
        req = (s.status | events) & s.mask;
        edge_only = (|req[icu_pkg::PINS-1:0]) && !(|req[icu_pkg::SRC_W-1:icu_pkg::ST_ROLL]);
        if (edge_only) begin
            lat = s.single ? icu_pkg::LAT_EDGE_SINGLE : icu_pkg::LAT_EDGE_MULTI; // RULE11
        end else begin
            lat = s.single ? icu_pkg::LAT_ROLL_SINGLE : icu_pkg::LAT_ROLL_MULTI; // RULE6
        end
        ret_lat = s.single ? icu_pkg::RET_SINGLE : icu_pkg::RET_MULTI; // RULE7

        case (s.fsm)
            icu_pkg::ICU_IDLE: begin
                if (|req) begin
                    n.fsm = icu_pkg::ICU_WAIT;
                    n.cnt = lat - 4'h1;
                end
            end
            icu_pkg::ICU_WAIT: begin
                if (s.cnt == 4'h1) begin
                    // Entry: shadow the context and vector the core
                    n.fsm = icu_pkg::ICU_SERVICE; // RULE1
                    n.saved = CORE_CTX; // RULE1
                    n.out.pc = icu_pkg::VECTOR_ADDR; // RULE2
                    n.out.status = CORE_CTX.status & icu_pkg::PAGE_CLR; // RULE3
                    n.out.file_select_pointer = CORE_CTX.file_select_pointer;
                    n.out.w = CORE_CTX.w;
                    n.load = 1'b1;
                    n.flush = 1'b1; // RULE8
                    n.cnt = 4'h0;
                end else begin
                    n.cnt = s.cnt - 4'h1;
                end
            end
            icu_pkg::ICU_SERVICE: begin
                // Requests stay sticky but start nothing while in service
                if (CORE_RETURN_FROM_INTERRUPT) begin
                    n.fsm = icu_pkg::ICU_RETURN;
                    n.cnt = ret_lat - 4'h1; // RULE7
                end
            end
            icu_pkg::ICU_RETURN: begin
                if (s.cnt == 4'h1) begin
                    n.fsm = icu_pkg::ICU_IDLE; // RULE4
                    n.out = s.saved; // RULE4
                    n.load = 1'b1;
                    n.flush = 1'b1; // RULE8
                    n.cnt = 4'h0;
                end else begin
                    n.cnt = s.cnt - 4'h1;
                end
            end
            default: begin
                n.fsm = icu_pkg::ICU_IDLE;
                n.cnt = 4'h0;
            end
        endcase

        if (CORE_PC_CHANGE) begin
            n.flush = 1'b1; // RULE8
        end

        n.in_service = (n.fsm == icu_pkg::ICU_SERVICE) || (n.fsm == icu_pkg::ICU_RETURN);
        n.hold = (n.fsm == icu_pkg::ICU_RETURN); // RULE7
        n.irq = |(n.status & n.mask);

        // Register reads, data in the following cycle only
        if (REG_RD) begin
            if (REG_ADDR == icu_pkg::OFS_CTRL) begin
                n.rdata[icu_pkg::CTRL_ROLL_DIS] = s.roll_dis;
                n.rdata[icu_pkg::CTRL_SINGLE] = s.single;
            end else if (REG_ADDR == icu_pkg::OFS_EDGE_EN) begin
                n.rdata[icu_pkg::PINS-1:0] = s.edge_en;
            end else if (REG_ADDR == icu_pkg::OFS_EDGE_DIR) begin
                n.rdata[icu_pkg::PINS-1:0] = s.edge_dir;
            end else if (REG_ADDR == icu_pkg::OFS_IRQ_STATUS) begin
                n.rdata[icu_pkg::SRC_W-1:0] = s.status;
            end else if (REG_ADDR == icu_pkg::OFS_IRQ_MASK) begin
                n.rdata[icu_pkg::SRC_W-1:0] = s.mask;
            end else if (REG_ADDR == icu_pkg::OFS_RTC) begin
                n.rdata[7:0] = s.rtc;
            end else if (REG_ADDR == icu_pkg::OFS_SAVED_PC) begin
                n.rdata[icu_pkg::PC_W-1:0] = s.saved.pc;
            end else if (REG_ADDR == icu_pkg::OFS_STATE) begin
                n.rdata[3:0] = s.fsm;
            end else begin
                n.rdata = '0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s.fsm <= icu_pkg::ICU_IDLE;
            s.cnt <= 4'h0;
            s.roll_dis <= icu_pkg::RST_ROLL_DIS;
            s.single <= icu_pkg::RST_SINGLE;
            s.edge_en <= icu_pkg::RST_EDGE_EN;
            s.edge_dir <= icu_pkg::RST_EDGE_DIR;
            s.status <= '0;
            s.mask <= icu_pkg::RST_MASK;
            s.rtc <= icu_pkg::RST_RTC;
            s.saved <= '0;
            s.out <= '0;
            s.load <= 1'b0;
            s.flush <= 1'b0;
            s.in_service <= 1'b0;
            s.hold <= 1'b0;
            s.irq <= 1'b0;
            s.rdata <= '0;
        end else begin
            s <= n;
        end
    end

    assign REG_RDATA = s.rdata;
    assign CTX_OUT = s.out;
    assign CTX_LOAD = s.load;
    assign PIPE_FLUSH = s.flush;
    assign IN_SERVICE = s.in_service;
    assign CORE_HOLD = s.hold;
    assign IRQ = s.irq;

endmodule

// ===== icu_chk.sv
// Port-level assertions for the interrupt context unit
module icu_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [icu_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [icu_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    // Core side
    input wire icu_pkg::icu_ctx_t CORE_CTX,
    input wire logic CORE_RETURN_FROM_INTERRUPT,
    input wire logic CORE_PC_CHANGE,
    input wire icu_pkg::icu_ctx_t CTX_OUT,
    input wire logic CTX_LOAD,
    input wire logic PIPE_FLUSH,
    input wire logic IN_SERVICE,
    input wire logic CORE_HOLD
);
    logic single;
    icu_pkg::icu_ctx_t prev_ctx;
    icu_pkg::icu_ctx_t saved;

    // Mirror of the mode bit, so return delay is judged per mode
    always_ff @(posedge CLK) begin
        if (RST) begin
            single <= 1'h0;
        end else if (REG_WR && REG_ADDR == icu_pkg::OFS_CTRL) begin
            single <= REG_WDATA[icu_pkg::CTRL_SINGLE];
        end
        prev_ctx <= CORE_CTX;
        if (CTX_LOAD && IN_SERVICE) begin
            saved <= prev_ctx;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_flush_pc_change: assert property (CORE_PC_CHANGE |=> PIPE_FLUSH)
        else $error("no flush after program counter change");
    a_load_flush: assert property (CTX_LOAD |-> PIPE_FLUSH)
        else $error("context load without flush");
    a_flush_cause: assert property (PIPE_FLUSH |-> CTX_LOAD || $past(CORE_PC_CHANGE))
        else $error("flush without cause");
    a_entry_vector: assert property ($rose(IN_SERVICE) |-> CTX_LOAD
        && CTX_OUT.pc == icu_pkg::VECTOR_ADDR) else $error("entry not at vector");
    a_entry_ctx: assert property ($rose(IN_SERVICE) |->
        CTX_OUT.status == ($past(CORE_CTX.status) & icu_pkg::PAGE_CLR)
        && CTX_OUT.file_select_pointer == $past(CORE_CTX.file_select_pointer)
        && CTX_OUT.w == $past(CORE_CTX.w))
        else $error("entry context wrong");
    a_no_reentry: assert property (IN_SERVICE && $past(IN_SERVICE) |-> !CTX_LOAD)
        else $error("load while in service");
    a_restore_ctx: assert property ($fell(IN_SERVICE) |-> CTX_LOAD && CTX_OUT == saved
        && !CORE_HOLD) else $error("resume context wrong");
    a_ret_single: assert property (IN_SERVICE && CORE_RETURN_FROM_INTERRUPT
        && !CORE_HOLD && single
        |=> CORE_HOLD [*2] ##1 (CTX_LOAD && !IN_SERVICE)) else $error("short return delay");
    a_ret_multi: assert property (IN_SERVICE && CORE_RETURN_FROM_INTERRUPT
        && !CORE_HOLD && !single
        |=> CORE_HOLD [*7] ##1 (CTX_LOAD && !IN_SERVICE)) else $error("long return delay");
endmodule

// ===== tb.sv
// Self-checking bench for the interrupt context unit
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic wr;
        logic [3:0] a;
        logic [15:0] d;
    } icu_row_t;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [15:0] reg_rdata;
    icu_pkg::icu_ctx_t core_ctx = '0;
    icu_pkg::icu_ctx_t ctx_exp;
    icu_pkg::icu_ctx_t ctx_out;
    logic core_return_from_interrupt = 1'h0;
    logic core_pc_change = 1'h0;
    logic rtc_tick = 1'h0;
    logic [7:0] port_b = 8'h00;
    logic [2:0] timer_evt = 3'h0;
    logic ctx_load, pipe_flush, in_service, core_hold, irq;
    int n_fail = 0;
    int cmp_count = 0;
    int n, m, s;
    // Reads carry the expected word in d
    icu_row_t rows [20] = '{
        '{1'h0, 4'h0, 16'h0001}, '{1'h0, 4'h1, 16'h0000}, '{1'h0, 4'h2, 16'h0000},
        '{1'h0, 4'h3, 16'h0000}, '{1'h0, 4'h4, 16'h0000}, '{1'h0, 4'h5, 16'h0000},
        '{1'h0, 4'h7, 16'h0001}, '{1'h0, 4'hF, 16'h0000}, '{1'h1, 4'h1, 16'hFFFF},
        '{1'h0, 4'h1, 16'h00FF}, '{1'h1, 4'h4, 16'hFFFF}, '{1'h0, 4'h4, 16'h0FFF},
        '{1'h1, 4'h5, 16'h00A5}, '{1'h0, 4'h5, 16'h00A5}, '{1'h1, 4'h7, 16'h0000},
        '{1'h0, 4'h7, 16'h0001}, '{1'h1, 4'hF, 16'hFFFF}, '{1'h0, 4'hF, 16'h0000},
        '{1'h1, 4'h0, 16'hFFFF}, '{1'h0, 4'h0, 16'h0003}};

    always #2.5 clk = ~clk;

    icu_top dut (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CORE_CTX(core_ctx),
        .CORE_RETURN_FROM_INTERRUPT(core_return_from_interrupt),
        .CORE_PC_CHANGE(core_pc_change), .RTC_TICK(rtc_tick),
        .PORT_B(port_b), .TIMER_EVT(timer_evt), .CTX_OUT(ctx_out), .CTX_LOAD(ctx_load),
        .PIPE_FLUSH(pipe_flush), .IN_SERVICE(in_service), .CORE_HOLD(core_hold), .IRQ(irq));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    // One edge; every pulse input lasts one cycle only
    task automatic step();
        @(posedge clk);
        rtc_tick <= 1'h0;
        timer_evt <= 3'h0;
        core_return_from_interrupt <= 1'h0;
        core_pc_change <= 1'h0;
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        step();
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        step();
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic wait_load(output int cnt);
        cnt = 0;
        do begin
            step();
            cnt++;
            #1;
        end while (ctx_load !== 1'h1 && cnt < 40);
        if (ctx_load !== 1'h1) begin
            n_fail++;
            end_of_test();
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a, rows[i].d);
            end
        end
        // Sources: rollover, pin edge, timer; single mode then multi mode
        for (int i = 0; i < 6; i++) begin
            m = i / 3;
            s = i % 3;
            ctx_exp = {11'h5A0 + 11'(i), 8'hE7, 8'h30 + 8'(i), 8'hC3};
            core_ctx <= ctx_exp;
            wr(4'h0, m ? 16'h0000 : 16'h0002);
            wr(4'h4, 16'h0FFF);
            wr(4'h1, 16'h00FF);
            wr(4'h2, m ? 16'h00FF : 16'h0000);
            if (s == 0) begin
                wr(4'h5, 16'h00FF);
            end
            case (s)
                0: rtc_tick <= 1'h1;
                1: port_b[0] <= ~port_b[0];
                default: timer_evt <= 3'(1 << m);
            endcase
            wait_load(n);
            chk(n, s == 1 ? (m ? 13 : 8) : (m ? 8 : 3));
            chk({ctx_out.pc, ctx_out.status}, {11'h000, 8'h07});
            chk({irq, in_service}, 2'h3);
            rd(4'h3, s == 0 ? 16'h0100 : s == 1 ? 16'h0001 : 16'h0200 << m);
            rd(4'h7, 16'h0004);
            timer_evt <= 3'h4;
            repeat (10) begin
                step();
                #1;
                chk(ctx_load, 1'h0);
            end
            wr(4'h3, 16'h0FFF);
            rd(4'h3, 16'h0000);
            chk(irq, 1'h0);
            core_return_from_interrupt <= 1'h1;
            wait_load(n);
            chk(n, m ? 8 : 3);
            chk({ctx_out, in_service, core_hold}, {ctx_exp, 2'h0});
            rd(4'h6, 16'(ctx_exp.pc));
        end
        // Rollover disabled, pin 0 disabled, pin 1 rising, all masked
        wr(4'h0, 16'h0003);
        wr(4'h4, 16'h0000);
        wr(4'h1, 16'h00FE);
        wr(4'h2, 16'h0000);
        wr(4'h5, 16'h00FF);
        rtc_tick <= 1'h1;
        port_b <= 8'h03;
        repeat (6) step();
        rd(4'h3, 16'h0002);
        chk({irq, in_service}, 2'h0);
        rd(4'h5, 16'h0000);
        wr(4'h3, 16'h0FFF);
        core_pc_change <= 1'h1;
        step();
        #1;
        chk(pipe_flush, 1'h1);
        rst <= 1'h1;
        repeat (2) step();
        rst <= 1'h0;
        rd(4'h0, 16'h0001);
        end_of_test();
    end
endmodule

bind icu_top icu_chk chk_i (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .CORE_CTX(CORE_CTX),
    .CORE_RETURN_FROM_INTERRUPT(CORE_RETURN_FROM_INTERRUPT),
    .CORE_PC_CHANGE(CORE_PC_CHANGE), .CTX_OUT(CTX_OUT), .CTX_LOAD(CTX_LOAD),
    .PIPE_FLUSH(PIPE_FLUSH), .IN_SERVICE(IN_SERVICE), .CORE_HOLD(CORE_HOLD));
